// ---- include/keypad_defines.svh ----
// register indices, field positions and reset values of the keypad interrupt unit
`ifndef KEYPAD_DEFINES_SVH
`define KEYPAD_DEFINES_SVH

// register index; byte address on the bus is four times the index
`define KP_IDX_W 6
`define KP_CTRL_IDX 6'h1a
`define KP_EN_IDX 6'h1b
`define KP_EVT_IDX 6'h1c
`define KP_EVTMSK_IDX 6'h1d

// keypad_status_control fields
`define KP_MODE_BIT 0
`define KP_MASK_BIT 1
`define KP_ACK_BIT 2
`define KP_PEND_BIT 3

// event status / event mask fields
`define KP_EVT_W 2
`define KP_EVT_LATCH_BIT 0
`define KP_EVT_CLEAR_BIT 1

`define KP_PIN6 3'h6
`define KP_CTRL_RST 8'h00
`define KP_EN_RST 8'h00
`define KP_EVT_RST 2'h0

`endif

// ---- include/keypad_pkg.sv ----
// types shared by the keypad interrupt unit
package keypad_pkg;

    typedef enum logic {
        sens_edge_only,
        sens_edge_level
    } sens_t;

    // readable image of keypad_status_control
    typedef struct packed {
        logic [3:0] zero;
        logic pending_flag;
        logic acknowledge_bit;
        logic interrupt_mask_bit;
        logic sensitivity_select;
    } ctrl_view_t;

    // one wishbone request as seen by the slave
    typedef struct packed {
        logic access;
        logic we;
        logic [5:0] idx;
        logic lane0;
        logic [7:0] wdata;
    } bus_req_t;

endpackage

// ---- rtl/keypad_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module keypad_pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] pins_out
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] filt_r;
    logic [WIDTH-1:0] filt_nxt;

    if (WIDTH < 1) begin : g_width_check
        $error("keypad_pin_sync: WIDTH must be at least 1");
    end

    // idle pins are pulled up, so reset to high
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s2_r[i] : filt_r[i];
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_r <= '1;
            s2_r <= '1;
            s3_r <= '1;
            filt_r <= '1;
        end else begin
            s1_r <= pins_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filt_nxt;
        end
    end

    assign pins_out = filt_r;

endmodule

// ---- rtl/keypad_wake_interrupt.sv ----
// keypad interrupt unit with wishbone register slave
`timescale 1ns/1ps
`include "keypad_defines.svh"

// Summary of operation
// - eight port A pins, each enabled alone, feed one shared keypad request
// - an enabled keypad pin, pin 6 only while it counts, forces its pull-up on, regardless of port pull-up bits
// - pin enable bit 1 enables its pin, 0 disables; read/write, resets to zero
// - request latches when an enabled pin falls after all enabled pins were high
// - edge-only mode: a fall while another enabled pin is low latches nothing
// - edge-and-level mode: request stays while any enabled pin is low
// - sensitivity select at bit 0: 1 edge plus level, 0 edge only
// - edge-and-level mode: clear needs acknowledge and all pins high, any order
// - a vector fetch acknowledges and clears the latched request
// - writing 1 to acknowledge bit 2 clears the request; it reads zero
// - a fall after a software acknowledge latches a fresh request
// - mask bit 1 blocks the request from the cpu when set
// - an unmasked request makes the cpu take the fixed keypad vector
// - pending flag bit 3 reads 1 while a request is pending
// - pin 6 counts only with the rc clock option and its port enable set
// - a pending unmasked request wakes the part from low-power modes
module keypad_wake_interrupt #(
    parameter int PINS = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic [PINS-1:0] port_a_pins_in,
    input wire logic [PINS-1:0] port_pullup_enable_in,
    input wire logic clock_option_select_in,
    input wire logic pin6_port_enable_in,
    input wire logic vector_fetch_in,
    output logic [PINS-1:0] pullup_on_out,
    output logic cpu_irq_out,
    output logic wake_out,
    output logic evt_irq_out
);

    // registers are one byte wide, so no other pin count fits
    if (PINS != 8) begin : g_pins_check
        $error("keypad_wake_interrupt: PINS must be 8 to fit the register layout");
    end

    logic [PINS-1:0] pins_f;
    keypad_pin_sync #(.WIDTH(PINS)) u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .pins_in(port_a_pins_in),
        .pins_out(pins_f)
    );

    // ---------------- register state ----------------
    logic [7:0] enable_r;
    logic [7:0] enable_nxt;
    keypad_pkg::sens_t mode_r;
    keypad_pkg::sens_t mode_nxt;
    logic mask_r;
    logic mask_nxt;
    logic [`KP_EVT_W-1:0] evt_r;
    logic [`KP_EVT_W-1:0] evt_nxt;
    logic [`KP_EVT_W-1:0] evtmsk_r;
    logic [`KP_EVT_W-1:0] evtmsk_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;

    // ---------------- request state ----------------
    logic req_r;
    logic req_nxt;
    logic ack_pend_r;
    logic ack_pend_nxt;
    logic prev_low_r;
    logic prev_low_nxt;
    logic cpu_irq_r;
    logic cpu_irq_nxt;
    logic evt_irq_r;
    logic evt_irq_nxt;
    logic [7:0] pullup_r;
    logic [7:0] pullup_nxt;

    keypad_pkg::bus_req_t bus;
    keypad_pkg::ctrl_view_t ctrl_view;
    logic [7:0] avail;
    logic [7:0] en_eff;
    logic any_low;
    logic sw_ack;
    logic ack_any;
    logic set_req;
    logic clr_req;

    always_comb begin
        bus.access = wb_cyc_in & wb_stb_in & ~ack_r;
        bus.we = wb_we_in;
        bus.idx = wb_adr_in[7:2];
        bus.lane0 = wb_sel_in[0];
        bus.wdata = wb_dat_in[7:0];
    end

    // pin 6 gated by clock option
    always_comb begin
        avail = 8'hff;
        avail[`KP_PIN6] = ~clock_option_select_in & pin6_port_enable_in;
    end

    // enabled pins merge into one request source
    assign en_eff = enable_r & avail;
    assign any_low = |(~pins_f & en_eff);

    assign sw_ack = bus.access & bus.we & bus.lane0 & (bus.idx == `KP_CTRL_IDX)
        & bus.wdata[`KP_ACK_BIT];
    assign ack_any = vector_fetch_in | sw_ack;

    // latch on first enabled pin falling
    // no latch while another enabled pin already low
    // level mode keeps the request while a pin is low
    always_comb begin
        set_req = any_low & ~prev_low_r;
        if (mode_r == keypad_pkg::sens_edge_level) begin
            set_req = any_low;
        end
    end

    // level mode clear needs ack and all pins high
    // edge mode clears on acknowledge alone
    always_comb begin
        if (mode_r == keypad_pkg::sens_edge_level) begin
            clr_req = (ack_any | ack_pend_r) & ~any_low;
        end else begin
            clr_req = ack_any;
        end
    end

    // a new edge beats a same-cycle acknowledge
    always_comb begin
        req_nxt = set_req | (req_r & ~clr_req);
        prev_low_nxt = any_low;
        ack_pend_nxt = req_nxt & (ack_pend_r | ack_any);
        // cpu takes the keypad vector on this level
        cpu_irq_nxt = req_nxt & ~mask_nxt;
    end

    always_comb begin
        pullup_nxt = port_pullup_enable_in | (enable_r & avail);
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_r <= 1'b0;
            ack_pend_r <= 1'b0;
            prev_low_r <= 1'b0;
            cpu_irq_r <= 1'b0;
            pullup_r <= 8'h00;
        end else begin
            req_r <= req_nxt;
            ack_pend_r <= ack_pend_nxt;
            prev_low_r <= prev_low_nxt;
            cpu_irq_r <= cpu_irq_nxt;
            pullup_r <= pullup_nxt;
        end
    end

    // ---------------- register file ----------------
    always_comb begin
        ctrl_view = '0;
        ctrl_view.pending_flag = req_r;
        ctrl_view.interrupt_mask_bit = mask_r;
        ctrl_view.sensitivity_select = mode_r;
    end

    always_comb begin
        enable_nxt = enable_r;
        mode_nxt = mode_r;
        mask_nxt = mask_r;
        evtmsk_nxt = evtmsk_r;
        evt_nxt = evt_r;
        ack_nxt = bus.access;
        dat_nxt = 32'h0000_0000;
        if (bus.access & bus.we & bus.lane0) begin
            unique case (bus.idx)
                `KP_CTRL_IDX: begin
                    mode_nxt = keypad_pkg::sens_t'(bus.wdata[`KP_MODE_BIT]);
                    mask_nxt = bus.wdata[`KP_MASK_BIT];
                end
                `KP_EN_IDX: begin
                    enable_nxt = bus.wdata;
                end
                `KP_EVTMSK_IDX: begin
                    evtmsk_nxt = bus.wdata[`KP_EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // pending flag reads back; ack bit reads zero
        if (bus.access & ~bus.we) begin
            unique case (bus.idx)
                `KP_CTRL_IDX: dat_nxt = {24'h00_0000, ctrl_view};
                `KP_EN_IDX: dat_nxt = {24'h00_0000, enable_r};
                `KP_EVT_IDX: begin
                    dat_nxt = {30'h0, evt_r};
                    evt_nxt = '0;
                end
                `KP_EVTMSK_IDX: dat_nxt = {30'h0, evtmsk_r};
                default: dat_nxt = 32'h0000_0000;
            endcase
        end
        // hardware set beats the read clear
        if (req_nxt & ~req_r) begin
            evt_nxt[`KP_EVT_LATCH_BIT] = 1'b1;
        end
        if (~req_nxt & req_r) begin
            evt_nxt[`KP_EVT_CLEAR_BIT] = 1'b1;
        end
        evt_irq_nxt = |(evt_nxt & evtmsk_nxt);
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_r <= `KP_EN_RST;
            mode_r <= keypad_pkg::sens_edge_only;
            mask_r <= 1'b0;
            evt_r <= `KP_EVT_RST;
            evtmsk_r <= `KP_EVT_RST;
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
            evt_irq_r <= 1'b0;
        end else begin
            enable_r <= enable_nxt;
            mode_r <= mode_nxt;
            mask_r <= mask_nxt;
            evt_r <= evt_nxt;
            evtmsk_r <= evtmsk_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            evt_irq_r <= evt_irq_nxt;
        end
    end

    assign wb_ack_out = ack_r;
    assign wb_dat_out = dat_r;
    assign pullup_on_out = pullup_r;
    assign cpu_irq_out = cpu_irq_r;
    assign wake_out = cpu_irq_r;
    assign evt_irq_out = evt_irq_r;

    // ---------------- assertions ----------------
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    AST_EDGE_LATCH: assert property (
        (any_low & ~prev_low_r) |=> req_r)
        else $error("enabled pin fall did not latch request");

    AST_EDGE_BLOCKED: assert property (
        (mode_r == keypad_pkg::sens_edge_only) & ~req_r & prev_low_r & ~vector_fetch_in
        |=> ~req_r)
        else $error("edge mode latched while a pin was already low");

    AST_LEVEL_HOLD: assert property (
        (mode_r == keypad_pkg::sens_edge_level) & any_low |=> req_r)
        else $error("level mode dropped request with pin low");

    AST_LEVEL_NEEDS_BOTH: assert property (
        (mode_r == keypad_pkg::sens_edge_level) & req_r & ~ack_any & ~ack_pend_r
        |=> req_r)
        else $error("level mode cleared without acknowledge");

    AST_FETCH_CLEARS: assert property (
        (mode_r == keypad_pkg::sens_edge_only) & vector_fetch_in & req_r & ~set_req
        |=> ~req_r & ~cpu_irq_out)
        else $error("vector fetch did not clear request");

    AST_SW_ACK: assert property (
        sw_ack & (mode_r == keypad_pkg::sens_edge_only) & ~set_req |=> ~req_r)
        else $error("acknowledge write did not clear request");

    AST_MASK: assert property (
        cpu_irq_out |-> req_r & ~mask_r)
        else $error("cpu request passed mask or without pending");

    AST_UNMASKED: assert property (
        req_r & ~mask_r & $stable(req_r) & $stable(mask_r) |-> cpu_irq_out)
        else $error("unmasked pending request not raised to cpu");

    AST_PENDING_READ: assert property (
        bus.access & ~bus.we & (bus.idx == `KP_CTRL_IDX)
        |=> wb_ack_out & (wb_dat_out[`KP_PEND_BIT] == $past(req_r))
        & (wb_dat_out[7:4] == 4'h0) & ~wb_dat_out[`KP_ACK_BIT])
        else $error("control read image wrong");

    AST_PIN6_GATE: assert property (
        clock_option_select_in |-> ~en_eff[`KP_PIN6])
        else $error("pin 6 active without rc option");

    AST_PULLUP: assert property (
        $stable(enable_r) & $stable(avail) & $stable(port_pullup_enable_in)
        |-> (pullup_on_out & en_eff) == en_eff)
        else $error("enabled pin without pull-up");

    AST_ACK_ONE_CYCLE: assert property (
        wb_ack_out |=> ~wb_ack_out)
        else $error("bus ack longer than one cycle");

    AST_LEVEL_CLEARS: assert property (
        (mode_r == keypad_pkg::sens_edge_level) & req_r & (ack_any | ack_pend_r) & ~any_low
        |=> ~req_r)
        else $error("level mode kept request after acknowledge and release");

    AST_EVT_LATCH: assert property (
        ~req_r ##1 req_r |-> evt_r[`KP_EVT_LATCH_BIT])
        else $error("request latch did not set event bit");

    COV_EDGE_REQ: cover property (
        (mode_r == keypad_pkg::sens_edge_only) & ~req_r ##1 req_r ##[1:20] ~req_r);
    COV_LEVEL_ACK_FIRST: cover property (
        (mode_r == keypad_pkg::sens_edge_level) & req_r & ack_any & any_low
        ##[1:50] ~req_r);
    COV_EVT_IRQ: cover property (evt_irq_out ##[1:20] ~evt_irq_out);
    COV_MASKED: cover property (req_r & mask_r);
    COV_PIN6_REQ: cover property (en_eff[`KP_PIN6] & ~pins_f[`KP_PIN6] & req_r);

endmodule

// ---- sim/keypad_keys.sv ----
// behavioural model of the keys wired to the port a pins
`timescale 1ns/1ps

module keypad_keys (
    input wire logic sys_clk_in,
    input wire logic [7:0] press_in,
    input wire logic [7:0] pullup_in,
    output logic [7:0] pins_out
);
    logic [7:0] float_r = 8'h00;

    // an open key with no pull-up floats, so show a level that keeps changing
    always @(posedge sys_clk_in) begin
        float_r <= ~float_r;
    end

    // a pressed key pulls low, a released one reads steadily high only with a pull-up
    assign pins_out = ~press_in & (pullup_in | float_r);
endmodule

// ---- sim/tb_top.sv ----
// self-checking testbench of the keypad interrupt unit
`timescale 1ns/1ps

module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, vf = 1'b0;
    logic cos = 1'b1, p6en = 1'b0, ack, irq, wake, evt;
    logic [7:0] adr = 8'h00, keys = 8'h00, pu_en = 8'h40, pins, pu_on;
    logic [3:0] sel = 4'h1;
    logic [31:0] wdat = 32'h0, rdat, rd;
    int failures = 0;
    int tests_run = 0;

    keypad_wake_interrupt DUT (.sys_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .port_a_pins_in(pins),
        .port_pullup_enable_in(pu_en), .clock_option_select_in(cos),
        .pin6_port_enable_in(p6en), .vector_fetch_in(vf), .pullup_on_out(pu_on),
        .cpu_irq_out(irq), .wake_out(wake), .evt_irq_out(evt));

    keypad_keys keys_model (.sys_clk_in(clk), .press_in(keys), .pullup_in(pu_on),
        .pins_out(pins));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic results();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // classic single cycle; the request stands until ack is sampled high
    task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            failures++;
            results();
        end
    endtask

    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        while (irq !== exp && n < 30) begin
            @(posedge clk);
            n++;
        end
        check({31'h0, irq}, {31'h0, exp});
        if (irq !== exp) begin
            results();
        end
    endtask

    task automatic press(input logic [7:0] k, input int settle);
        @(posedge clk);
        keys <= k;
        repeat (settle) @(posedge clk);
    endtask

    task automatic fetch();
        @(posedge clk);
        vf <= 1'b1;
        @(posedge clk);
        vf <= 1'b0;
    endtask

    task automatic regs_scenario();
        bus(0, 6'h1a, 8'h00);
        check(rd, 32'h0);
        bus(0, 6'h1b, 8'h00);
        check(rd, 32'h0);
        bus(1, 6'h1a, 8'hff);
        bus(0, 6'h1a, 8'h00);
        check(rd, 32'h3);
        bus(1, 6'h1b, 8'ha5);
        bus(0, 6'h1b, 8'h00);
        check(rd, 32'ha5);
        bus(0, 6'h3f, 8'h00);
        check(rd, 32'h0);
        bus(1, 6'h1a, 8'h00);
        bus(1, 6'h1b, 8'h0f);
        press(8'h00, 3);
        check({24'h0, pu_on}, 32'h4f);
    endtask

    task automatic edge_scenario();
        press(8'h01, 0);
        wait_irq(1);
        bus(0, 6'h1a, 8'h00);
        check(rd, 32'h8);
        check({31'h0, wake}, 32'h1);
        bus(1, 6'h1a, 8'h04);
        wait_irq(0);
        press(8'h03, 10);
        check({31'h0, irq}, 32'h0);
        press(8'h01, 2);
        // the stuck pin is taken out so the next fall counts
        bus(1, 6'h1b, 8'h0e);
        press(8'h03, 0);
        wait_irq(1);
        fetch();
        wait_irq(0);
        bus(1, 6'h1b, 8'h0f);
        press(8'h00, 8);
    endtask

    task automatic level_scenario();
        bus(1, 6'h1a, 8'h01);
        press(8'h01, 0);
        wait_irq(1);
        fetch();
        repeat (8) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        press(8'h00, 0);
        wait_irq(0);
        press(8'h02, 0);
        wait_irq(1);
        press(8'h00, 10);
        check({31'h0, irq}, 32'h1);
        bus(1, 6'h1a, 8'h05);
        wait_irq(0);
    endtask

    task automatic mask_scenario();
        bus(1, 6'h1a, 8'h02);
        press(8'h04, 10);
        check({30'h0, wake, irq}, 32'h0);
        bus(0, 6'h1a, 8'h00);
        check(rd, 32'ha);
        bus(1, 6'h1a, 8'h00);
        wait_irq(1);
        bus(1, 6'h1a, 8'h04);
        wait_irq(0);
        press(8'h00, 8);
    endtask

    task automatic pin6_scenario();
        bus(1, 6'h1b, 8'h40);
        @(posedge clk);
        p6en <= 1'b1;
        press(8'h40, 10);
        check({31'h0, irq}, 32'h0);
        // let the release pass the filter before pin 6 becomes available
        press(8'h00, 6);
        cos <= 1'b0;
        press(8'h00, 4);
        press(8'h40, 0);
        wait_irq(1);
        bus(1, 6'h1a, 8'h04);
        press(8'h00, 8);
        bus(1, 6'h1b, 8'h0f);
    endtask

    task automatic event_scenario();
        bus(0, 6'h1c, 8'h00);
        bus(1, 6'h1d, 8'h01);
        press(8'h08, 0);
        wait_irq(1);
        repeat (2) @(posedge clk);
        check({31'h0, evt}, 32'h1);
        bus(0, 6'h1c, 8'h00);
        check(rd, 32'h1);
        bus(1, 6'h1a, 8'h04);
        repeat (2) @(posedge clk);
        check({31'h0, evt}, 32'h0);
        bus(0, 6'h1c, 8'h00);
        check(rd, 32'h2);
        press(8'h00, 8);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        regs_scenario();
        edge_scenario();
        level_scenario();
        mask_scenario();
        pin6_scenario();
        event_scenario();
        results();
    end
endmodule
